// ### hw/ocr_pkg.sv
// Purpose: Constants for the fuse-backed sensor configuration register bank.
// Assumes: Byte-wide register access and a 100 MHz system clock.
// Notes:   Times are kept in milliseconds; the cycle counts derive from them.
package ocr_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned FUSE_FAST_MS    = 100;
  localparam int unsigned FUSE_SLOW_MS    = 200;
  localparam int unsigned POR_MS_0        = 50;
  localparam int unsigned POR_MS_1        = 100;
  localparam int unsigned POR_MS_2        = 200;
  localparam int unsigned POR_MS_3        = 300;
  localparam int unsigned FUSE_FAST_CYC   = FUSE_FAST_MS * CYC_PER_MS;
  localparam int unsigned FUSE_SLOW_CYC   = FUSE_SLOW_MS * CYC_PER_MS;
  localparam int unsigned POR_CYC_0       = POR_MS_0 * CYC_PER_MS;
  localparam int unsigned POR_CYC_1       = POR_MS_1 * CYC_PER_MS;
  localparam int unsigned POR_CYC_2       = POR_MS_2 * CYC_PER_MS;
  localparam int unsigned POR_CYC_3       = POR_MS_3 * CYC_PER_MS;
  // Register offsets.
  localparam logic [7:0]  ADDR_CHIP_REVISION  = 8'h00;
  localparam logic [7:0]  ADDR_SENSOR_CONFIG  = 8'h07;
  localparam logic [7:0]  ADDR_FUSE_CONTROL   = 8'h08;
  localparam logic [7:0]  ADDR_AUTO_CHECK     = 8'h0B;
  localparam logic [7:0]  ADDR_MODE_REQUEST   = 8'h2A;
  localparam logic [7:0]  ADDR_MODE_VALID     = 8'h36;
  localparam logic [7:0]  ADDR_PROGRAM_CMD    = 8'h39;
  // Codes.
  localparam logic [7:0]  MODE_REQUEST_CODE    = 8'h3C;
  localparam logic [7:0]  MODE_VALIDATION_CODE = 8'h96;
  localparam logic [7:0]  PROGRAM_COMMAND_CODE = 8'hB0;
  localparam logic [7:0]  WO_READ_VALUE        = 8'h00;
  // Field positions.
  localparam int unsigned CFG_REG_BIT     = 6;
  localparam int unsigned CFG_POR_HI      = 5;
  localparam int unsigned CFG_POR_LO      = 4;
  localparam int unsigned CFG_NO_BIT      = 3;
  localparam int unsigned CFG_PP_BIT      = 2;
  localparam int unsigned CFG_LOW_BIT     = 1;
  localparam int unsigned CFG_STR_BIT     = 0;
  localparam int unsigned CFG_USED_MSB    = 6;
  localparam int unsigned CTL_TRANSP_BIT  = 0;
  localparam int unsigned CHK_AUTO_BIT    = 7;
  localparam int unsigned CHK_SLOW_BIT    = 6;
  localparam int unsigned CHK_MAKER_BANK_LOCK_BIT    = 5;
  localparam int unsigned CHK_CUSTOMER_BANK_LOCK_BIT    = 4;
  localparam int unsigned CHK_BLCK_BIT    = 3;
  localparam int unsigned CHK_RUN_BIT     = 2;
  // Reset values.
  localparam logic [6:0]  CFG_RESET       = 7'h00;
  localparam logic        TRANSP_RESET    = 1'b1;
  typedef enum logic [0:0] {OCR_IDLE, OCR_BURN} ocr_burn_t;
endpackage

// ### hw/ocr_bank.sv
// Purpose: Fuse-backed configuration register bank of a sensor output driver.
// Assumes: A serial front end delivers decoded byte reads and writes on clk_sys.
// Notes:   The fuse array is modelled as a register image burnt by the auto sequence.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] Bit 6 selects 3.3V or 5V regulator
// [RULE2] Bits 5:4 select 50/100/200/300ms power-on delay
// [RULE3] Bit 3 selects normally closed or open
// [RULE4] Bit 2 selects open-drain or push-pull
// [RULE5] Bit 1 selects high or low side; low_side_select is forced 0 while bit 2 selects push-pull
// [RULE6] Bit 0 enables output pulse stretching
// [RULE7] Transparency bit resets 1; 0 applies directly
// [RULE8] Programmer keeps transparency 1 for burning
// [RULE9] Programmer preserves reserved control bits
// [RULE10] Check bit 7 enables automatic programming
// [RULE11] Check bit 6 picks 100 or 200ms
// [RULE12] Customer lock reads 1, refuses programming
// [RULE13] Write 0x3C to 0x2A requests mode
// [RULE14] Then 0x96 to 0x36 enters mode
// [RULE15] Other validation value leaves programming mode
// [RULE16] 0xB0 to 0x39 starts auto programming
// [RULE17] Read-only writes ignored; write-only reads constant
// [RULE18] Config registers writable only in programming mode
module ocr_bank
  import ocr_pkg::*;
#(
  parameter logic [7:0]  REVISION_CODE = 8'h5A, // Arbitrary value.
  parameter int unsigned FAST_CYC      = FUSE_FAST_CYC,
  parameter int unsigned SLOW_CYC      = FUSE_SLOW_CYC,
  parameter int unsigned POR0_CYC      = POR_CYC_0,
  parameter int unsigned POR1_CYC      = POR_CYC_1,
  parameter int unsigned POR2_CYC      = POR_CYC_2,
  parameter int unsigned POR3_CYC      = POR_CYC_3
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       maker_bank_lock,
  output logic            program_mode,
  output logic            auto_program_running,
  output logic            regulator_voltage_select,
  output logic      [1:0] power_on_delay_select,
  output logic            normally_open_select,
  output logic            push_pull_select,
  output logic            low_side_select,
  output logic            pulse_stretch_enable,
  output logic            power_on_done
);
  import ocr_pkg::*;

  typedef struct packed {
    logic [6:0]  cfg;
    logic [6:0]  fuse;
    logic [6:0]  live;
    logic        transp;
    logic        auto_en;
    logic        slow;
    logic        clock_lck;
    logic        requested;
    logic        mode;
    ocr_burn_t   burn;
    logic [31:0] burn_cnt;
    logic [31:0] por_cnt;
    logic        por_done;
    logic [7:0]  rdata;
    logic        rvalid;
  } ocr_state_t;

  ocr_state_t st;
  ocr_state_t next_st;
  logic       wr_cfg;
  logic       wr_ctl;
  logic       wr_chk;
  logic       wr_req;
  logic       wr_val;
  logic       wr_cmd;
  logic       start_burn;
  logic [31:0] por_limit;
  logic [31:0] burn_limit;

  //////////////////////////////////////////////////////////////////////////////
  assign wr_cfg = reg_write && reg_addr == ADDR_SENSOR_CONFIG && st.mode; // [RULE18]
  assign wr_ctl = reg_write && reg_addr == ADDR_FUSE_CONTROL && st.mode;  // [RULE18]
  assign wr_chk = reg_write && reg_addr == ADDR_AUTO_CHECK && st.mode;    // [RULE18]
  assign wr_req = reg_write && reg_addr == ADDR_MODE_REQUEST;
  assign wr_val = reg_write && reg_addr == ADDR_MODE_VALID;
  assign wr_cmd = reg_write && reg_addr == ADDR_PROGRAM_CMD;
  // Burning needs the mode, the enable, an opaque fuse array and an open bank.
  assign start_burn = wr_cmd && reg_wdata == PROGRAM_COMMAND_CODE && st.mode && st.auto_en
                      && st.transp && !st.clock_lck && st.burn == OCR_IDLE; // [RULE16] [RULE12]
  assign burn_limit = st.slow ? SLOW_CYC : FAST_CYC; // [RULE11]

  always_comb begin
    case (st.live[CFG_POR_HI:CFG_POR_LO]) // [RULE2]
      2'b00:   por_limit = POR0_CYC;
      2'b01:   por_limit = POR1_CYC;
      2'b10:   por_limit = POR2_CYC;
      default: por_limit = POR3_CYC;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    if (wr_cfg) begin
      next_st.cfg = reg_wdata[CFG_USED_MSB:0];
    end
    if (wr_ctl) begin
      next_st.transp = reg_wdata[CTL_TRANSP_BIT]; // [RULE7]
    end
    if (wr_chk) begin
      next_st.auto_en = reg_wdata[CHK_AUTO_BIT]; // [RULE10]
      next_st.slow    = reg_wdata[CHK_SLOW_BIT]; // [RULE11]
    end
    if (wr_req) begin
      next_st.requested = reg_wdata == MODE_REQUEST_CODE; // [RULE13]
    end
    if (wr_val) begin
      if (reg_wdata == MODE_VALIDATION_CODE && st.requested) begin
        next_st.mode = 1'b1; // [RULE14]
      end else if (reg_wdata != MODE_VALIDATION_CODE) begin
        next_st.mode      = 1'b0; // [RULE15]
        next_st.requested = 1'b0;
      end
    end
    // A transparent array passes the written settings straight to the outputs.
    next_st.live = st.transp ? st.fuse : st.cfg; // [RULE7]
    case (st.burn)
      OCR_IDLE: begin
        if (start_burn) begin
          next_st.burn     = OCR_BURN;
          next_st.burn_cnt = 32'h0000_0000;
        end
      end
      OCR_BURN: begin
        next_st.burn_cnt = st.burn_cnt + 32'h0000_0001;
        if (st.burn_cnt + 32'h0000_0001 >= burn_limit) begin
          next_st.burn      = OCR_IDLE;
          next_st.fuse      = st.cfg;
          next_st.clock_lck = 1'b1; // [RULE12]
        end
      end
      default: next_st.burn = OCR_IDLE;
    endcase
    if (!st.por_done) begin
      next_st.por_cnt = st.por_cnt + 32'h0000_0001;
      if (st.por_cnt + 32'h0000_0001 >= por_limit) begin
        next_st.por_done = 1'b1; // [RULE2]
      end
    end
    if (reg_read) begin
      next_st.rvalid = 1'b1;
      case (reg_addr)
        ADDR_CHIP_REVISION: next_st.rdata = REVISION_CODE;
        ADDR_SENSOR_CONFIG: next_st.rdata = {1'b0, st.cfg};
        ADDR_FUSE_CONTROL:  next_st.rdata = {7'h00, st.transp}; // [RULE9]
        ADDR_AUTO_CHECK: begin
          next_st.rdata               = 8'h00;
          next_st.rdata[CHK_AUTO_BIT] = st.auto_en;
          next_st.rdata[CHK_SLOW_BIT] = st.slow;
          next_st.rdata[CHK_MAKER_BANK_LOCK_BIT] = maker_bank_lock;
          next_st.rdata[CHK_CUSTOMER_BANK_LOCK_BIT] = st.clock_lck; // [RULE12]
          next_st.rdata[CHK_BLCK_BIT] = st.clock_lck;
          next_st.rdata[CHK_RUN_BIT]  = st.burn == OCR_BURN;
        end
        default: next_st.rdata = WO_READ_VALUE; // [RULE17]
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st           <= '0;
      st.cfg       <= CFG_RESET;
      st.fuse      <= CFG_RESET;
      st.live      <= CFG_RESET;
      st.transp    <= TRANSP_RESET; // [RULE7]
      st.burn      <= OCR_IDLE;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign reg_rdata                = st.rdata;
  assign reg_rvalid               = st.rvalid;
  assign program_mode             = st.mode;
  assign auto_program_running     = st.burn == OCR_BURN;
  assign regulator_voltage_select = st.live[CFG_REG_BIT]; // [RULE1]
  assign power_on_delay_select    = st.live[CFG_POR_HI:CFG_POR_LO];
  assign normally_open_select     = st.live[CFG_NO_BIT]; // [RULE3]
  assign push_pull_select         = st.live[CFG_PP_BIT]; // [RULE4]
  // Low-side choice only matters when the push-pull stage is off.
  assign low_side_select          = st.live[CFG_LOW_BIT] && !st.live[CFG_PP_BIT]; // [RULE5]
  assign pulse_stretch_enable     = st.live[CFG_STR_BIT]; // [RULE6]
  assign power_on_done            = st.por_done;

  //////////////////////////////////////////////////////////////////////////////
  AST_ENTER_MODE: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE14]
    (reg_write && reg_addr == ADDR_MODE_VALID && reg_wdata == MODE_VALIDATION_CODE
     && st.requested) |=> program_mode)
    else $error("validation code did not enter programming mode");
  AST_LEAVE_MODE: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE15]
    (reg_write && reg_addr == ADDR_MODE_VALID && reg_wdata != MODE_VALIDATION_CODE)
    |=> !program_mode)
    else $error("bad validation value left programming mode on");
  AST_NO_REQ_NO_MODE: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE13]
    (!program_mode && !st.requested) |=> !program_mode)
    else $error("programming mode entered without a request");
  AST_LOCKED_CFG: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE18]
    (reg_write && reg_addr == ADDR_SENSOR_CONFIG && !program_mode) |=> $stable(st.cfg))
    else $error("configuration changed outside programming mode");
  AST_TRANSPARENT: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE7]
    !st.transp |=> (pulse_stretch_enable == $past(st.cfg[CFG_STR_BIT])))
    else $error("transparent settings did not reach the outputs");
  AST_START: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE16]
    start_burn |=> auto_program_running)
    else $error("program command did not start the burn");
  AST_LOCK_REFUSE: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE12]
    (st.clock_lck && !auto_program_running) |=> !auto_program_running)
    else $error("burn started on a locked bank");
  AST_BURN_TIME: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE11]
    (auto_program_running && !$past(auto_program_running) && FAST_CYC > 2)
    |-> auto_program_running[*2])
    else $error("burn ended too early");
  AST_AUTO_GATE: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE10]
    (!st.auto_en && !auto_program_running) |=> !auto_program_running)
    else $error("burn started with automatic programming disabled");
  AST_WO_READ: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE17]
    (reg_read && (reg_addr == ADDR_MODE_REQUEST || reg_addr == ADDR_PROGRAM_CMD))
    |=> (reg_rvalid && reg_rdata == WO_READ_VALUE))
    else $error("write-only register read back a value");
  AST_LOW_SIDE: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE5]
    push_pull_select |-> !low_side_select)
    else $error("low-side select active with push-pull");
  // Register access: mode request, read-back values, refused and accepted writes.
  AST_REQ_SET: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE13]
    (reg_write && reg_addr == ADDR_MODE_REQUEST && reg_wdata == MODE_REQUEST_CODE)
    |=> st.requested)
    else $error("mode request code was not recorded");
  AST_REQ_CLEAR: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE13]
    (reg_write && reg_addr == ADDR_MODE_REQUEST && reg_wdata != MODE_REQUEST_CODE)
    |=> !st.requested)
    else $error("wrong request code kept the request");
  AST_WO_VAL_READ: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE17]
    (reg_read && reg_addr == ADDR_MODE_VALID)
    |=> (reg_rvalid && reg_rdata == WO_READ_VALUE))
    else $error("validation register read back a value");
  AST_REV_READ: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE17]
    (reg_read && reg_addr == ADDR_CHIP_REVISION)
    |=> (reg_rvalid && reg_rdata == REVISION_CODE))
    else $error("revision read returned a wrong value");
  AST_RVALID_IDLE: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE17]
    !reg_read
    |=> !reg_rvalid)
    else $error("read valid pulsed without a read");
  AST_CTL_LOCKED: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE18]
    (reg_write && reg_addr == ADDR_FUSE_CONTROL && !program_mode)
    |=> $stable(st.transp))
    else $error("control changed outside programming mode");
  AST_CHK_LOCKED: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE18]
    (reg_write && reg_addr == ADDR_AUTO_CHECK && !program_mode)
    |=> ($stable(st.auto_en) && $stable(st.slow)))
    else $error("check mode changed outside programming mode");
  AST_CFG_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE18]
    (reg_write && reg_addr == ADDR_SENSOR_CONFIG && program_mode)
    |=> (st.cfg == $past(reg_wdata[CFG_USED_MSB:0])))
    else $error("configuration write in programming mode was lost");
  // Outputs: what the pins show for each transparency setting.
  AST_OPAQUE: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE7]
    st.transp
    |=> (pulse_stretch_enable == $past(st.fuse[CFG_STR_BIT])))
    else $error("opaque array did not show the fuse image");
  AST_REG_OUT: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE1]
    !st.transp
    |=> (regulator_voltage_select == $past(st.cfg[CFG_REG_BIT])))
    else $error("regulator select did not follow the configuration");
  AST_DELAY_OUT: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE2]
    !st.transp
    |=> (power_on_delay_select == $past(st.cfg[CFG_POR_HI:CFG_POR_LO])))
    else $error("power-on delay select did not follow the configuration");
  AST_POLARITY_OUT: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE3]
    !st.transp
    |=> (normally_open_select == $past(st.cfg[CFG_NO_BIT])))
    else $error("contact polarity did not follow the configuration");
  // Burn sequence: no stray start, full length, lock at the end.
  AST_NO_STRAY_BURN: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE16]
    (!start_burn && !auto_program_running)
    |=> !auto_program_running)
    else $error("burn started without a program command");
  AST_BURN_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE11]
    (auto_program_running && st.burn_cnt + 32'h0000_0001 < burn_limit)
    |=> auto_program_running)
    else $error("burn stopped before its write time");
  AST_BURN_LOCKS: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE12]
    $fell(auto_program_running)
    |-> st.clock_lck)
    else $error("finished burn left the bank unlocked");
endmodule // ocr_bank

// ### sim/ocr_programmer.sv
// Purpose: Behavioural model of the serial programmer on the register port.
// Assumes: Requests change just after a rising clk_sys edge.
// Notes:   Released address and data lines carry the inverse of the last value.
`timescale 1ns/100ps
module ocr_programmer (
  input  wire logic       clk_sys,
  output logic            reg_write,
  output logic            reg_read,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  import ocr_pkg::*;
  initial begin
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    d = 8'hXX;
    for (int i = 0; i < 3; i++) begin
      #1;
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
      @(posedge clk_sys);
    end
  endtask
  task automatic enter_mode();
    wr(ADDR_MODE_REQUEST, MODE_REQUEST_CODE);
    wr(ADDR_MODE_VALID, MODE_VALIDATION_CODE);
  endtask
  // Reserved control bits go out as zero, the value they read back as.
  task automatic set_ctl(input logic transp);
    wr(ADDR_FUSE_CONTROL, {7'h00, transp});
  endtask
  task automatic burn(input logic slow);
    set_ctl(1'b1);
    wr(ADDR_AUTO_CHECK, {1'b1, slow, 6'h00});
    wr(ADDR_PROGRAM_CMD, PROGRAM_COMMAND_CODE);
  endtask
endmodule // ocr_programmer

// ### sim/ocr_bank_tb_top.sv
// Purpose: Self-checking bench for the fuse configuration register bank.
// Assumes: Short burn and power-on counts so the run stays brief.
// Notes:   Each burn is preceded by a reset, since a burn locks the bank.
`timescale 1ns/100ps
module ocr_bank_tb_top;
  import ocr_pkg::*;
  localparam int unsigned FAST = 20;
  localparam int unsigned SLOW = 40;
  localparam logic [7:0]  REV  = 8'hA5; // Arbitrary value.
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic       maker_bank_lock = 1'b0;
  logic       reg_write, reg_read, reg_rvalid, program_mode, auto_program_running;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       regulator_voltage_select, normally_open_select, push_pull_select;
  logic       low_side_select, pulse_stretch_enable, power_on_done;
  logic [1:0] power_on_delay_select;
  int         error_cnt = 0;
  int         compares = 0;
  wire  [7:0] cfg_out = {1'b0, regulator_voltage_select, power_on_delay_select,
                         normally_open_select, push_pull_select, low_side_select,
                         pulse_stretch_enable};
  always #5 clk_sys = ~clk_sys;
  ocr_bank #(.REVISION_CODE(REV), .FAST_CYC(FAST), .SLOW_CYC(SLOW), .POR0_CYC(10),
    .POR1_CYC(20), .POR2_CYC(30), .POR3_CYC(40)) uut (.clk_sys(clk_sys),
    .reset_n(reset_n), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .maker_bank_lock(maker_bank_lock), .program_mode(program_mode),
    .auto_program_running(auto_program_running),
    .regulator_voltage_select(regulator_voltage_select),
    .power_on_delay_select(power_on_delay_select),
    .normally_open_select(normally_open_select), .push_pull_select(push_pull_select),
    .low_side_select(low_side_select), .pulse_stretch_enable(pulse_stretch_enable),
    .power_on_done(power_on_done));
  ocr_programmer prog (.clk_sys(clk_sys), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    prog.rd(a, d);
    chk(n, e, d);
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask
  // Low side only has meaning for the open-drain stage, so push-pull masks it.
  function automatic logic [7:0] exp_out(input logic [7:0] d);
    return {1'b0, d[6:2], d[1] & ~d[2], d[0]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    static logic [7:0] pat [4] = '{8'hFF, 8'h4A, 8'h25, 8'h12};
    int n;
    do_reset();
    @(negedge clk_sys);
    chk("cfg_out", 8'h00, cfg_out);
    chk("power_on_done", 8'h00, {7'h00, power_on_done});
    rchk("fuse_control", ADDR_FUSE_CONTROL, 8'h01);
    prog.wr(ADDR_CHIP_REVISION, 8'h00);
    rchk("chip_revision", ADDR_CHIP_REVISION, REV);
    prog.wr(ADDR_SENSOR_CONFIG, 8'h7F);
    rchk("sensor_configuration", ADDR_SENSOR_CONFIG, 8'h00);
    prog.wr(ADDR_MODE_VALID, MODE_VALIDATION_CODE);
    repeat (2) @(negedge clk_sys);
    chk("program_mode", 8'h00, {7'h00, program_mode});
    chk("power_on_done", 8'h01, {7'h00, power_on_done});
    prog.enter_mode();
    repeat (2) @(negedge clk_sys);
    chk("program_mode", 8'h01, {7'h00, program_mode});
    rchk("program_mode_request", ADDR_MODE_REQUEST, WO_READ_VALUE);
    rchk("unmapped", 8'h55, 8'h00);
    rchk("program_mode_validation", ADDR_MODE_VALID, WO_READ_VALUE);
    rchk("program_command", ADDR_PROGRAM_CMD, WO_READ_VALUE);
    prog.set_ctl(1'b0);
    foreach (pat[i]) begin
      prog.wr(ADDR_SENSOR_CONFIG, pat[i]);
      repeat (2) @(negedge clk_sys);
      chk("cfg_out", exp_out(pat[i]), cfg_out);
      rchk("sensor_configuration", ADDR_SENSOR_CONFIG, {1'b0, pat[i][6:0]});
    end
    prog.wr(ADDR_MODE_VALID, 8'h55);
    repeat (2) @(negedge clk_sys);
    chk("program_mode", 8'h00, {7'h00, program_mode});
    prog.wr(ADDR_SENSOR_CONFIG, 8'h00);
    rchk("sensor_configuration", ADDR_SENSOR_CONFIG, 8'h12);
    prog.wr(ADDR_MODE_REQUEST, MODE_REQUEST_CODE);
    prog.wr(ADDR_MODE_REQUEST, 8'h00);
    prog.wr(ADDR_MODE_VALID, MODE_VALIDATION_CODE);
    repeat (2) @(negedge clk_sys);
    chk("program_mode", 8'h00, {7'h00, program_mode});
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk_sys);
      maker_bank_lock <= s[0];
      do_reset();
      prog.enter_mode();
      prog.wr(ADDR_PROGRAM_CMD, PROGRAM_COMMAND_CODE);
      @(negedge clk_sys);
      chk("auto_program_running", 8'h00, {7'h00, auto_program_running});
      prog.wr(ADDR_SENSOR_CONFIG, 8'h15);
      prog.burn(s[0]);
      n = 0;
      #1;
      while (auto_program_running === 1'b1 && n < 100) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      chk("burn_cycles", 8'(s ? SLOW : FAST), n[7:0]);
      rchk("auto_program_check", ADDR_AUTO_CHECK, {1'b1, s[0], s[0], 5'h18});
      @(negedge clk_sys);
      chk("cfg_out", exp_out(8'h15), cfg_out);
      prog.wr(ADDR_PROGRAM_CMD, PROGRAM_COMMAND_CODE);
      @(negedge clk_sys);
      chk("auto_program_running", 8'h00, {7'h00, auto_program_running});
    end
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    end_of_test();
  end
endmodule // ocr_bank_tb_top
